// [rtl/timer16_compare_output_mode_control.sv]
// timer 16 control registers, compare output decode, clock select and capture input
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Notes on behaviour
// - a nonzero channel A mode hands the port pin to compare output A, except 01 in pwm outside waveform 9, 11, 14 or 15
// - channel B mode 10 or 11 hands the port pin to compare output B; 01 does so only outside pwm
// - channel C mode 10 or 11 hands the port pin to compare output C; 01 does so only outside pwm
// - plain and clear-on-match: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast pwm mode 10: clear on match, set at bottom
// - fast pwm mode 11: set on match, clear at bottom
// - fast pwm mode 01: only channel A toggles, waveform 14 or 15
// - fast pwm: match at TOP with upper bit set is ignored
// - dual slope mode 10: clear on up match, set on down match
// - dual slope mode 11: set on up match, clear on down match
// - dual slope mode 01: only channel A toggles, waveform 9 or 11
// - waveform mode is control B bits 4:3 above control A bits 1:0
// - plain, clear-on-match, fast and dual slope pwm kinds exist; phase and phase-frequency pwm share dual slope
// - control B: filter, edge, reserved zero, waveform high, clock select
// - control A sits at its own index, all fields read-write, reset zero
// - clock select: stop, divide 1/8/64/256/1024, external fall or rise
// - edge select zero captures falling edge, one captures rising edge
// - filter needs four equal samples before its output changes
module timer16_compare_output_mode_control
	import timer16_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [11:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        match_a,
	input  wire logic        match_b,
	input  wire logic        match_c,
	input  wire logic        top_match_a,
	input  wire logic        top_match_b,
	input  wire logic        top_match_c,
	input  wire logic        at_bottom,
	input  wire logic        count_up,
	input  wire logic        ext_clock_pin,
	input  wire logic        capture_input_pin,
	output logic             compare_out_a,
	output logic             compare_out_b,
	output logic             compare_out_c,
	output logic             override_a,
	output logic             override_b,
	output logic             override_c,
	output logic [3:0]       waveform_mode_select,
	output logic             timer_tick,
	output logic             capture_event
);
	function automatic logic reg_hit(input logic [11:0] addr, input logic [8:0] idx);
		reg_hit = (addr == {1'b0, idx, 2'b00});
	endfunction

	logic [7:0]  t1_control_b_r;
	logic [7:0]  t3_control_b_r;
	logic [7:0]  t4_control_b_r;
	logic [7:0]  t5_control_a_r;
	logic [7:0]  t5_control_b_r;
	logic        capture_flag_r;
	logic        ack_r;
	logic [7:0]  rd_byte;
	logic        req;
	logic        wr_take;
	logic        byte0_en;
	logic        flag_clear;
	wave_kind_t  kind;
	logic [2:0]  match_vec;
	logic [2:0]  top_vec;
	logic [2:0]  out_vec;
	logic [2:0]  ovr_vec;
	logic [PRESCALE_BITS-1:0] pre_cnt_r;
	logic        ext_s1_r;
	logic        ext_s2_r;
	logic        ext_s3_r;
	logic        tick_nxt;
	logic        cap_s1_r;
	logic        cap_s2_r;
	logic [3:0]  hist_r;
	logic        filtered_r;
	logic        prev_filt_r;
	logic        edge_seen;

	// bus slave: one wait state, data prepared while waitrequest is high
	assign req         = read || write;
	assign waitrequest = req && !ack_r;
	assign wr_take     = write && ack_r;
	assign byte0_en    = byteenable[0];

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ack_r <= 1'b0;
		else
			ack_r <= req && !ack_r;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			t1_control_b_r <= CONTROL_B_RESET;
			t3_control_b_r <= CONTROL_B_RESET;
			t4_control_b_r <= CONTROL_B_RESET;
			t5_control_a_r <= CONTROL_A_RESET;
			t5_control_b_r <= CONTROL_B_RESET;
		end
		else if (wr_take && byte0_en)
		begin
			if (reg_hit(address, IDX_T1_CONTROL_B))
				t1_control_b_r <= writedata[7:0] & CONTROL_B_WMASK;
			if (reg_hit(address, IDX_T3_CONTROL_B))
				t3_control_b_r <= writedata[7:0] & CONTROL_B_WMASK;
			if (reg_hit(address, IDX_T4_CONTROL_B))
				t4_control_b_r <= writedata[7:0] & CONTROL_B_WMASK;
			if (reg_hit(address, IDX_T5_CONTROL_A))
				t5_control_a_r <= writedata[7:0];
			if (reg_hit(address, IDX_T5_CONTROL_B))
				t5_control_b_r <= writedata[7:0] & CONTROL_B_WMASK;
		end
	end

	always_comb
	begin
		rd_byte = 8'h00;
		if (reg_hit(address, IDX_T1_CONTROL_B))
			rd_byte = t1_control_b_r;
		else if (reg_hit(address, IDX_T3_CONTROL_B))
			rd_byte = t3_control_b_r;
		else if (reg_hit(address, IDX_T4_CONTROL_B))
			rd_byte = t4_control_b_r;
		else if (reg_hit(address, IDX_T5_CONTROL_A))
			rd_byte = t5_control_a_r;
		else if (reg_hit(address, IDX_T5_CONTROL_B))
			rd_byte = t5_control_b_r;
		else if (reg_hit(address, IDX_T5_STATUS))
		begin
			rd_byte[STAT_CAPTURE_FLAG] = capture_flag_r;
			rd_byte[STAT_CAPTURE_LVL]  = filtered_r;
			rd_byte[STAT_OUT_LO +: 3]  = out_vec;
			rd_byte[STAT_OVR_LO +: 3]  = ovr_vec;
		end
	end

	// unmapped reads return zero
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			readdata <= 32'h0000_0000;
		else if (read && !ack_r)
			readdata <= {24'h00_0000, rd_byte};
	end

	// waveform mode and its kind
	assign waveform_mode_select = {t5_control_b_r[WGM_HIGH_HI:WGM_HIGH_LO],
		t5_control_a_r[WGM_LOW_HI:WGM_LOW_LO]};
	assign kind = wave_kind(waveform_mode_select);

	assign match_vec = {match_c, match_b, match_a};
	assign top_vec   = {top_match_c, top_match_b, top_match_a};

	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1)
		begin : g_chan
			compare_output_unit u_unit (
				.clk            (clk),
				.reset          (reset),
				.kind           (kind),
				.wgm            (waveform_mode_select),
				.out_mode       (t5_control_a_r[MODE_FIELD_TOP - 2*ch -: 2]),
				.is_chan_a      (ch == 0),
				.match          (match_vec[ch]),
				.at_bottom      (at_bottom),
				.count_up       (count_up),
				.compare_is_top (top_vec[ch]),
				.pin_out        (out_vec[ch]),
				.override       (ovr_vec[ch])
			);
		end
	endgenerate

	// direction stays with the port logic; only value and takeover leave here
	assign compare_out_a = out_vec[0];
	assign compare_out_b = out_vec[1];
	assign compare_out_c = out_vec[2];
	assign override_a    = ovr_vec[0];
	assign override_b    = ovr_vec[1];
	assign override_c    = ovr_vec[2];

	// prescaler runs free; a shared counter keeps all taps phase aligned
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pre_cnt_r <= '0;
		else
			pre_cnt_r <= pre_cnt_r + 1'b1;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end
		else
		begin
			ext_s1_r <= ext_clock_pin;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	always_comb
	begin
		unique case (t5_control_b_r[CLK_SEL_HI:CLK_SEL_LO])
			CS_STOP:     tick_nxt = 1'b0;
			CS_DIV1:     tick_nxt = 1'b1;
			CS_DIV8:     tick_nxt = &pre_cnt_r[2:0];
			CS_DIV64:    tick_nxt = &pre_cnt_r[5:0];
			CS_DIV256:   tick_nxt = &pre_cnt_r[7:0];
			CS_DIV1024:  tick_nxt = &pre_cnt_r[9:0];
			CS_EXT_FALL: tick_nxt = ext_s3_r && !ext_s2_r;
			CS_EXT_RISE: tick_nxt = !ext_s3_r && ext_s2_r;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			timer_tick <= 1'b0;
		else
			timer_tick <= tick_nxt;
	end

	// capture input: sync, optional four-sample filter, edge select
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cap_s1_r <= 1'b0;
			cap_s2_r <= 1'b0;
			hist_r   <= 4'h0;
		end
		else
		begin
			cap_s1_r <= capture_input_pin;
			cap_s2_r <= cap_s1_r;
			hist_r   <= {hist_r[2:0], cap_s2_r};
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			filtered_r <= 1'b0;
		else if (!t5_control_b_r[FILTER_EN_BIT])
			filtered_r <= cap_s2_r;
		else if (hist_r == 4'hf)
			filtered_r <= 1'b1;
		else if (hist_r == 4'h0)
			filtered_r <= 1'b0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			prev_filt_r <= 1'b0;
		else
			prev_filt_r <= filtered_r;
	end

	assign edge_seen = t5_control_b_r[EDGE_SEL_BIT] ? (filtered_r && !prev_filt_r)
		: (!filtered_r && prev_filt_r);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			capture_event <= 1'b0;
		else
			capture_event <= edge_seen;
	end

	// sticky flag: write one clears, a capture in the same cycle wins
	assign flag_clear = wr_take && byte0_en && reg_hit(address, IDX_T5_STATUS)
		&& writedata[STAT_CAPTURE_FLAG];

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			capture_flag_r <= 1'b0;
		else if (capture_event)
			capture_flag_r <= 1'b1;
		else if (flag_clear)
			capture_flag_r <= 1'b0;
	end

	a_override_chan_a: assert property (@(posedge clk) disable iff (reset)
		(t5_control_a_r[7:6] != OM_OFF && (kind == KIND_PLAIN || kind == KIND_CLEAR))
		|-> override_a)
		else $error("channel a did not take the pin");

	a_reserved_reads_zero: assert property (@(posedge clk) disable iff (reset)
		(read && ack_r && reg_hit(address, IDX_T5_CONTROL_B)) |-> !readdata[RESERVED_B_BIT])
		else $error("reserved control b bit read as one");

	a_write_control_a: assert property (@(posedge clk) disable iff (reset)
		(wr_take && byte0_en && reg_hit(address, IDX_T5_CONTROL_A))
		|=> (t5_control_a_r == $past(writedata[7:0])))
		else $error("control a write lost");

	a_div8_spacing: assert property (@(posedge clk) disable iff (reset)
		(t5_control_b_r[CLK_SEL_HI:CLK_SEL_LO] == CS_DIV8 && timer_tick
		&& $stable(t5_control_b_r)) |=> !timer_tick [*7])
		else $error("divide by eight tick too early");

	a_capture_rise: assert property (@(posedge clk) disable iff (reset)
		($rose(filtered_r) && t5_control_b_r[EDGE_SEL_BIT]) |=> capture_event)
		else $error("rising capture edge missed");

	a_filter_stable: assert property (@(posedge clk) disable iff (reset)
		($past(t5_control_b_r[FILTER_EN_BIT]) && (filtered_r != $past(filtered_r)))
		|-> ($past(hist_r) == {4{filtered_r}}))
		else $error("filter output changed without four equal samples");

	a_flag_set_wins: assert property (@(posedge clk) disable iff (reset)
		capture_event |=> capture_flag_r)
		else $error("capture flag lost");

	a_flag_write_clear: assert property (@(posedge clk) disable iff (reset)
		(flag_clear && !capture_event) |=> !capture_flag_r)
		else $error("capture flag not cleared by write");

	a_override_chan_b: assert property (@(posedge clk) disable iff (reset)
		t5_control_a_r[5] |-> override_b)
		else $error("channel b did not take the pin");

	a_override_chan_c: assert property (@(posedge clk) disable iff (reset)
		t5_control_a_r[3] |-> override_c)
		else $error("channel c did not take the pin");

endmodule

// [rtl/timer16_ctrl_pkg.sv]
// shared constants, types and decode functions for the 16-bit timer control block
package timer16_ctrl_pkg;

	// register indices; byte address is four times the index
	localparam logic [8:0] IDX_T1_CONTROL_B = 9'h081;
	localparam logic [8:0] IDX_T3_CONTROL_B = 9'h091;
	localparam logic [8:0] IDX_T4_CONTROL_B = 9'h0a1;
	localparam logic [8:0] IDX_T5_CONTROL_A = 9'h120;
	localparam logic [8:0] IDX_T5_CONTROL_B = 9'h121;
	localparam logic [8:0] IDX_T5_STATUS    = 9'h12f;

	localparam logic [7:0] CONTROL_A_RESET = 8'h00;
	localparam logic [7:0] CONTROL_B_RESET = 8'h00;

	// control A layout
	localparam int MODE_FIELD_TOP = 7;
	localparam int WGM_LOW_HI     = 1;
	localparam int WGM_LOW_LO     = 0;

	// control B layout
	localparam int FILTER_EN_BIT   = 7;
	localparam int EDGE_SEL_BIT    = 6;
	localparam int RESERVED_B_BIT  = 5;
	localparam int WGM_HIGH_HI     = 4;
	localparam int WGM_HIGH_LO     = 3;
	localparam int CLK_SEL_HI      = 2;
	localparam int CLK_SEL_LO      = 0;
	localparam logic [7:0] CONTROL_B_WMASK = 8'hdf;

	// status layout
	localparam int STAT_CAPTURE_FLAG = 0;
	localparam int STAT_CAPTURE_LVL  = 1;
	localparam int STAT_OUT_LO       = 2;
	localparam int STAT_OVR_LO       = 5;

	// clock source codes
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESCALE_BITS = 10;

	// compare output mode codes
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;

	// waveform modes where channel A may toggle in PWM
	localparam logic [3:0] WGM_FAST_TOG_0 = 4'he;
	localparam logic [3:0] WGM_FAST_TOG_1 = 4'hf;
	localparam logic [3:0] WGM_DUAL_TOG_0 = 4'h9;
	localparam logic [3:0] WGM_DUAL_TOG_1 = 4'hb;

	typedef enum logic [3:0] {
		KIND_PLAIN = 4'h1,
		KIND_CLEAR = 4'h2,
		KIND_FAST  = 4'h4,
		KIND_DUAL  = 4'h8
	} wave_kind_t;

	function automatic wave_kind_t wave_kind(input logic [3:0] wgm);
		case (wgm)
			4'h0:                      wave_kind = KIND_PLAIN;
			4'h4, 4'hc:                wave_kind = KIND_CLEAR;
			4'h5, 4'h6, 4'h7, 4'he, 4'hf: wave_kind = KIND_FAST;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: wave_kind = KIND_DUAL;
			default:                   wave_kind = KIND_PLAIN;
		endcase
	endfunction

	// channel A toggle permission in the PWM kinds
	function automatic logic toggle_allowed(input wave_kind_t kind, input logic [3:0] wgm);
		toggle_allowed = ((kind == KIND_FAST) && (wgm == WGM_FAST_TOG_0 || wgm == WGM_FAST_TOG_1))
			|| ((kind == KIND_DUAL) && (wgm == WGM_DUAL_TOG_0 || wgm == WGM_DUAL_TOG_1));
	endfunction

endpackage

// [rtl/compare_output_unit.sv]
// one compare output channel: mode decode, pin takeover and output flip-flop
`timescale 1ns/1ps
module compare_output_unit
	import timer16_ctrl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire wave_kind_t kind,
	input  wire logic [3:0] wgm,
	input  wire logic [1:0] out_mode,
	input  wire logic       is_chan_a,
	input  wire logic       match,
	input  wire logic       at_bottom,
	input  wire logic       count_up,
	input  wire logic       compare_is_top,
	output logic            pin_out,
	output logic            override
);
	logic pwm;
	logic tog_ok;
	logic pin_nxt;

	assign pwm    = (kind == KIND_FAST) || (kind == KIND_DUAL);
	assign tog_ok = is_chan_a && toggle_allowed(kind, wgm);

	// toggle code in PWM without permission leaves the port pin alone
	assign override = (out_mode != OM_OFF)
		&& !(pwm && out_mode == OM_TOGGLE && !tog_ok);

	always_comb
	begin
		pin_nxt = pin_out;
		unique case (kind)
			KIND_PLAIN, KIND_CLEAR:
			begin
				if (match)
				begin
					unique case (out_mode)
						OM_TOGGLE: pin_nxt = !pin_out;
						OM_CLEAR:  pin_nxt = 1'b0;
						OM_SET:    pin_nxt = 1'b1;
						default:   pin_nxt = pin_out;
					endcase
				end
			end
			KIND_FAST:
			begin
				// match at TOP is dropped in modes 10 and 11 so bottom alone decides the level
				if (match && !(out_mode[1] && compare_is_top))
				begin
					unique case (out_mode)
						OM_TOGGLE: pin_nxt = tog_ok ? !pin_out : pin_out;
						OM_CLEAR:  pin_nxt = 1'b0;
						OM_SET:    pin_nxt = 1'b1;
						default:   pin_nxt = pin_out;
					endcase
				end
				else if (at_bottom && out_mode[1])
				begin
					pin_nxt = !out_mode[0];
				end
			end
			KIND_DUAL:
			begin
				if (match)
				begin
					unique case (out_mode)
						OM_TOGGLE: pin_nxt = tog_ok ? !pin_out : pin_out;
						OM_CLEAR:  pin_nxt = !count_up;
						OM_SET:    pin_nxt = count_up;
						default:   pin_nxt = pin_out;
					endcase
				end
			end
			default: pin_nxt = pin_out;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pin_out <= 1'b0;
		else
			pin_out <= pin_nxt;
	end

	a_toggle_on_match: assert property (@(posedge clk) disable iff (reset)
		((kind == KIND_PLAIN || kind == KIND_CLEAR) && out_mode == OM_TOGGLE && match)
		|=> (pin_out == !$past(pin_out)))
		else $error("plain mode toggle missed");

	a_fast_bottom_set: assert property (@(posedge clk) disable iff (reset)
		(kind == KIND_FAST && out_mode == OM_CLEAR && at_bottom && !match) |=> pin_out)
		else $error("fast pwm output not set at bottom");

	a_fast_inv_match: assert property (@(posedge clk) disable iff (reset)
		(kind == KIND_FAST && out_mode == OM_SET && match && !compare_is_top) |=> pin_out)
		else $error("inverting fast pwm not set on match");

	a_fast_top_ignored: assert property (@(posedge clk) disable iff (reset)
		(kind == KIND_FAST && out_mode[1] && match && compare_is_top && !at_bottom)
		|=> $stable(pin_out))
		else $error("match at top was not ignored");

	a_dual_up_clear: assert property (@(posedge clk) disable iff (reset)
		(kind == KIND_DUAL && out_mode == OM_CLEAR && match && count_up) |=> !pin_out)
		else $error("dual slope output not cleared counting up");

	a_dual_down_clear: assert property (@(posedge clk) disable iff (reset)
		(kind == KIND_DUAL && out_mode == OM_SET && match && !count_up) |=> !pin_out)
		else $error("inverted dual slope not cleared counting down");

	a_pwm_toggle_off: assert property (@(posedge clk) disable iff (reset)
		(pwm && out_mode == OM_TOGGLE && !is_chan_a) |-> (!override ##1 $stable(pin_out)))
		else $error("channel b or c toggled in pwm");

endmodule

// [sim/port_pin_model.sv]
// port pin model: direction bit, normal port data and compare output takeover
`timescale 1ns/1ps
module port_pin_model
(
	input  wire logic dir,
	input  wire logic port_data,
	input  wire logic override,
	input  wire logic compare_out,
	output logic      pin
);
	// pin driver is off without direction, so the pull-up wins even under takeover
	assign pin = dir ? (override ? compare_out : port_data) : 1'b1;
endmodule

// [sim/timer16_compare_output_mode_control_tb_top.sv]
// self-checking bench for the timer 16 control block
`timescale 1ns/1ps
module timer16_compare_output_mode_control_tb_top;
	import timer16_ctrl_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [11:0] address = 12'h000;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0]  byteenable = 4'h1;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [2:0]  match = 3'h0;
	logic [2:0]  top_match = 3'h0;
	logic        at_bottom = 1'b0;
	logic        count_up = 1'b1;
	logic        ext_pin = 1'b0;
	logic        cap_pin = 1'b1;
	logic [2:0]  dir = 3'h7;
	logic        port_data = 1'b1;
	logic [2:0]  cout;
	logic [2:0]  ovr;
	logic [2:0]  pin;
	logic [3:0]  wms;
	logic        tick;
	logic        cap_evt;
	logic [7:0]  rd_q[$];
	logic [7:0]  d;
	logic [8:0]  regs[5] = '{IDX_T1_CONTROL_B, IDX_T3_CONTROL_B, IDX_T4_CONTROL_B,
		IDX_T5_CONTROL_A, IDX_T5_CONTROL_B};
	int          divs[6] = '{0, 1, 8, 64, 256, 1024};
	int          fail_count = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          c;

	timer16_compare_output_mode_control timer16_compare_output_mode_control_inst (
		.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .match_a(match[0]), .match_b(match[1]),
		.match_c(match[2]), .top_match_a(top_match[0]), .top_match_b(top_match[1]),
		.top_match_c(top_match[2]), .at_bottom(at_bottom), .count_up(count_up),
		.ext_clock_pin(ext_pin), .capture_input_pin(cap_pin),
		.compare_out_a(cout[0]), .compare_out_b(cout[1]), .compare_out_c(cout[2]),
		.override_a(ovr[0]), .override_b(ovr[1]), .override_c(ovr[2]),
		.waveform_mode_select(wms), .timer_tick(tick), .capture_event(cap_evt));

	for (genvar i = 0; i < 3; i++)
	begin : pins
		port_pin_model port_pin_model_inst (.dir(dir[i]), .port_data(port_data),
			.override(ovr[i]), .compare_out(cout[i]), .pin(pin[i]));
	end

	always #5 clk = ~clk;

	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmp_val(input logic [31:0] act, input logic [31:0] exp);
		n_compared++;
		if (act !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask

	task automatic cmp_cnt(input int act, input int exp);
		n_compared++;
		if (act != exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask

	// request held until the rising edge that samples waitrequest low
	task automatic bus(input logic wr, input logic [3:0] be, input logic [8:0] idx,
		input logic [7:0] dat);
		@(posedge clk);
		address    <= {1'b0, idx, 2'b00};
		read       <= !wr;
		write      <= wr;
		byteenable <= be;
		writedata  <= {24'h00_0000, dat};
		if (!wr)
			rd_q.push_back(dat);
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [8:0] idx, input logic [7:0] dat);
		bus(1'b1, 4'h1, idx, dat);
	endtask

	task automatic rd(input logic [8:0] idx, input logic [7:0] exp);
		bus(1'b0, 4'h1, idx, exp);
	endtask

	task automatic setm(input logic [3:0] w, input logic [1:0] ma, mb, mc);
		wr(IDX_T5_CONTROL_A, {ma, mb, mc, w[1:0]});
		wr(IDX_T5_CONTROL_B, {3'h0, w[3:2], 3'h0});
		@(negedge clk);
		cmp_val(32'(wms), 32'(w));
	endtask

	// one cycle of counter events, output checked once it has landed
	task automatic ev(input logic [2:0] m, input logic bot, input logic up,
		input logic [2:0] exp);
		@(posedge clk);
		match     <= m;
		at_bottom <= bot;
		count_up  <= up;
		@(posedge clk);
		match     <= 3'h0;
		at_bottom <= 1'b0;
		@(negedge clk);
		cmp_val(32'(cout), 32'(exp));
	endtask

	task automatic count(input logic cap, input int n, output int cnt);
		cnt = 0;
		repeat (n)
		begin
			@(negedge clk);
			if ((cap ? cap_evt : tick) === 1'b1)
				cnt++;
		end
	endtask

	task automatic drv(input logic ext, input logic v);
		@(posedge clk);
		if (ext)
			ext_pin <= v;
		else
			cap_pin <= v;
	endtask

	// read data taken at the same edge that samples waitrequest low
	always @(posedge clk)
		if (read === 1'b1 && waitrequest === 1'b0 && rd_q.size() > 0)
			cmp_val(readdata, {24'h00_0000, rd_q.pop_front()});

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fail_count++;
			$display("Error at %0t: run exceeded %h cycles", $time, cyc);
			final_report();
		end
	end

	initial
	begin
		d = 8'($urandom(9173));
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		foreach (regs[i])
			rd(regs[i], 8'h00);
		foreach (regs[i])
		begin
			d = 8'($urandom());
			wr(regs[i], d);
			rd(regs[i], (regs[i] == IDX_T5_CONTROL_A) ? d : (d & CONTROL_B_WMASK));
		end
		wr(IDX_T5_CONTROL_A, 8'h5a);
		bus(1'b1, 4'h0, IDX_T5_CONTROL_A, 8'ha5);
		rd(IDX_T5_CONTROL_A, 8'h5a);
		wr(9'h100, 8'hff);
		rd(9'h100, 8'h00);
		for (int k = 0; k < 16; k++)
			setm(4'(k), OM_OFF, OM_OFF, OM_OFF);
		$display("test registers done");
		for (int w = 0; w < 8; w += 4)
		begin
			setm(4'(w), OM_SET, OM_SET, OM_SET);
			cmp_val(32'(ovr), 32'h0000_0007);
			ev(3'h7, 1'b0, 1'b1, 3'h7);
			setm(4'(w), OM_CLEAR, OM_CLEAR, OM_CLEAR);
			ev(3'h7, 1'b0, 1'b1, 3'h0);
			setm(4'(w), OM_TOGGLE, OM_TOGGLE, OM_TOGGLE);
			ev(3'h1, 1'b0, 1'b1, 3'h1);
			ev(3'h6, 1'b0, 1'b1, 3'h7);
		end
		setm(4'h0, OM_CLEAR, OM_CLEAR, OM_OFF);
		ev(3'h3, 1'b0, 1'b1, 3'h4);
		cmp_val(32'(pin), 32'h0000_0004);
		@(posedge clk);
		dir <= 3'h6;
		@(negedge clk);
		cmp_val(32'(pin), 32'h0000_0005);
		$display("test non-pwm done");
		setm(4'he, OM_CLEAR, OM_CLEAR, OM_SET);
		ev(3'h0, 1'b1, 1'b1, 3'h3);
		ev(3'h7, 1'b0, 1'b1, 3'h4);
		ev(3'h0, 1'b1, 1'b1, 3'h3);
		@(posedge clk);
		top_match <= 3'h1;
		ev(3'h1, 1'b0, 1'b1, 3'h3);
		@(posedge clk);
		top_match <= 3'h0;
		setm(4'he, OM_TOGGLE, OM_TOGGLE, OM_TOGGLE);
		cmp_val(32'(ovr), 32'h0000_0001);
		ev(3'h1, 1'b0, 1'b1, 3'h2);
		setm(4'h5, OM_TOGGLE, OM_TOGGLE, OM_TOGGLE);
		cmp_val(32'(ovr), 32'h0000_0000);
		$display("test fast pwm done");
		setm(4'h9, OM_CLEAR, OM_SET, OM_CLEAR);
		ev(3'h7, 1'b0, 1'b1, 3'h2);
		ev(3'h7, 1'b0, 1'b0, 3'h5);
		setm(4'h1, OM_SET, OM_CLEAR, OM_SET);
		ev(3'h7, 1'b0, 1'b0, 3'h2);
		setm(4'hb, OM_TOGGLE, OM_TOGGLE, OM_TOGGLE);
		cmp_val(32'(ovr), 32'h0000_0001);
		ev(3'h1, 1'b0, 1'b1, 3'h3);
		setm(4'h1, OM_TOGGLE, OM_TOGGLE, OM_TOGGLE);
		cmp_val(32'(ovr), 32'h0000_0000);
		$display("test dual-slope pwm done");
		for (int s = 0; s < 6; s++)
		begin
			wr(IDX_T5_CONTROL_B, 8'(s));
			repeat (8) @(negedge clk);
			count(1'b0, 1024, c);
			cmp_cnt(c, (s == 0) ? 0 : 1024 / divs[s]);
		end
		for (int s = 6; s < 8; s++)
		begin
			wr(IDX_T5_CONTROL_B, 8'(s));
			repeat (8) @(negedge clk);
			drv(1'b1, 1'b1);
			count(1'b0, 8, c);
			cmp_cnt(c, s - 6);
			drv(1'b1, 1'b0);
			count(1'b0, 8, c);
			cmp_cnt(c, 7 - s);
		end
		$display("test clock select done");
		wr(IDX_T5_CONTROL_B, 8'h00);
		drv(1'b0, 1'b0);
		count(1'b1, 8, c);
		cmp_cnt(c, 1);
		drv(1'b0, 1'b1);
		count(1'b1, 8, c);
		cmp_cnt(c, 0);
		wr(IDX_T5_CONTROL_B, 8'h40);
		drv(1'b0, 1'b0);
		count(1'b1, 8, c);
		cmp_cnt(c, 0);
		drv(1'b0, 1'b1);
		count(1'b1, 8, c);
		cmp_cnt(c, 1);
		wr(IDX_T5_CONTROL_B, 8'hc0);
		drv(1'b0, 1'b0);
		count(1'b1, 16, c);
		drv(1'b0, 1'b1);
		count(1'b1, 5, c);
		cmp_cnt(c, 0);
		count(1'b1, 10, c);
		cmp_cnt(c, 1);
		// two-sample glitch must not get through the filter
		drv(1'b0, 1'b0);
		@(posedge clk);
		drv(1'b0, 1'b1);
		count(1'b1, 16, c);
		cmp_cnt(c, 0);
		// status: flag set by earlier captures, level high, outputs a and b high
		rd(IDX_T5_STATUS, 8'h0f);
		wr(IDX_T5_STATUS, 8'h01);
		rd(IDX_T5_STATUS, 8'h0e);
		$display("test capture done");
		final_report();
	end
endmodule
